// File: carrier_src.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Far-side carrier source: one high burst, then a low gap, idle low between bursts
module carrier_src (
	// Clock and trigger
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] hi_len_i,
	input wire logic [7:0] lo_len_i,
	// Carrier pin and status
	output logic pin_o,
	output logic busy_o
);
	logic [8:0] cnt_q;

	// Known idle level from time zero, so no edge is seen before the first burst
	initial begin
		pin_o = 1'b0;
		busy_o = 1'b0;
		cnt_q = 9'h000;
	end

	// Widths are whole clock cycles, so a short burst probes the glitch filter
	always @(posedge clk_i) begin
		if (go_i && !busy_o) begin
			busy_o <= 1'b1;
			pin_o <= 1'b1;
			cnt_q <= {1'b0, hi_len_i} + {1'b0, lo_len_i} - 9'h001;
		end else if (busy_o) begin
			if (cnt_q == {1'b0, lo_len_i}) begin
				pin_o <= 1'b0;
			end
			if (cnt_q == 9'h000) begin
				busy_o <= 1'b0;
			end
			cnt_q <= cnt_q - 9'h001;
		end
	end
endmodule

// File: carrier_timer.sv
`timescale 1ns/100ps
module carrier_timer import ctp_pkg::*; (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// Carrier inputs
	input wire logic PORT3_BIT1_INPUT_I,
	input wire logic PORT2_BIT0_INPUT_I,
	// Timer outputs and interrupt requests
	output logic BYTE_TIMER_OUTPUT_O,
	output logic WORD_TIMER_OUTPUT_O,
	output logic BYTE_IRQ_O,
	output logic WORD_IRQ_O,
	// AXI4-Lite write channels
	input wire logic [5:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	// AXI4-Lite read channels
	input wire logic [5:0] AXI_ARADDR_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I
);

	// Sticky flag update; a hardware set wins over a software clear
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	logic rst_meta_q, rst_n_q;
	logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [3:0] aw_idx_q;
	logic [7:0] wdata_q;
	logic wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] b_cfg_q, w_cfg_q, common_q, bhold_lo_q, bhold_hi_q, whold_lo_q, whold_hi_q;
	logic [7:0] rise_cap_q, fall_cap_q, b_cnt_q;
	logic [15:0] w_cap_q, w_cnt_q;
	logic sync_q, b_en_q, w_en_q, b_to_q, w_to_q, rise_f_q, fall_f_q, w_arm_q;
	logic b_run_q, w_run_q, b_out_q, w_out_q, b_irq_q, w_irq_q;
	logic filt_q, filt_prev_q;
	logic [3:0] flt_cnt_q;

	// Reset release through two flops
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!rst_n_q);

	////////////////////////////////////////////////////////////////////////////
	// Register bus

	logic wr_go;
	assign wr_go = aw_have_q & w_have_q & ~bvalid_q;

	// Write strobe for one register; only the low byte lane carries data
	function automatic logic wr_hit(input logic go, input logic stb, input logic [3:0] a,
			input logic [3:0] idx);
		return go & stb & (a == idx);
	endfunction

	logic wr_bctl, wr_com, wr_wctl, wr_sync;
	assign wr_bctl = wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_BYTE_CTL);
	assign wr_com = wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_COMMON);
	assign wr_wctl = wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_WORD_CTL);
	assign wr_sync = wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_SYNC);

	// Address and data are taken in either order; response after both
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_idx_q <= IDX_BYTE_CTL;
			wdata_q <= CTL_RESET;
			wstrb_q <= 1'b0;
		end else begin
			if (AXI_AWVALID_I && awready_q) begin
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
				aw_idx_q <= AXI_AWADDR_I[5:2];
			end
			if (AXI_WVALID_I && wready_q) begin
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q <= AXI_WDATA_I[7:0];
				wstrb_q <= AXI_WSTRB_I[0];
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (aw_idx_q > IDX_WORD_CAP) ? RESP_SLVERR : RESP_OKAY;
			end
			if (bvalid_q && AXI_BREADY_I) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Read mux; flag bits of the common register show by mode
	logic [31:0] rd_mux;
	logic [3:0] rd_idx;
	always_comb begin
		rd_idx = AXI_ARADDR_I[5:2];
		rd_mux = '0;
		unique case (rd_idx)
			IDX_BYTE_CTL: rd_mux[7:0] = (b_cfg_q & CFG_MASK) | {b_en_q, 1'b0, b_to_q, 5'h00};
			IDX_COMMON: rd_mux[7:0] = common_q[MODE_B] ?
				{common_q[7:2], rise_f_q, fall_f_q} : common_q;
			IDX_WORD_CTL: rd_mux[7:0] = (w_cfg_q & CFG_MASK) | {w_en_q, 1'b0, w_to_q, 5'h00};
			IDX_SYNC: rd_mux[7:0] = {w_en_q, b_en_q, sync_q, RSV_ONES};
			IDX_BHOLD_LO: rd_mux[7:0] = bhold_lo_q;
			IDX_BHOLD_HI: rd_mux[7:0] = bhold_hi_q;
			IDX_WHOLD_LO: rd_mux[7:0] = whold_lo_q;
			IDX_WHOLD_HI: rd_mux[7:0] = whold_hi_q;
			IDX_RISE_CAP: rd_mux[7:0] = rise_cap_q;
			IDX_FALL_CAP: rd_mux[7:0] = fall_cap_q;
			IDX_WORD_CAP: rd_mux[15:0] = w_cap_q;
			default: rd_mux = '0;
		endcase
	end

	// Read answers one cycle after the address is taken
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (AXI_ARVALID_I && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= (rd_idx > IDX_WORD_CAP) ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_q && AXI_RREADY_I) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Plain configuration registers; sync bit clears on reset
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			b_cfg_q <= CTL_RESET;
			w_cfg_q <= CTL_RESET;
			common_q <= CTL_RESET;
			sync_q <= 1'b0;
			bhold_lo_q <= CTL_RESET;
			bhold_hi_q <= CTL_RESET;
			whold_lo_q <= CTL_RESET;
			whold_hi_q <= CTL_RESET;
		end else begin
			if (wr_bctl) b_cfg_q <= wdata_q;
			if (wr_wctl) w_cfg_q <= wdata_q;
			if (wr_sync) sync_q <= wdata_q[SYNC_B];
			if (wr_com) common_q <= wdata_q;
			if (wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_BHOLD_LO)) bhold_lo_q <= wdata_q;
			if (wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_BHOLD_HI)) bhold_hi_q <= wdata_q;
			if (wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_WHOLD_LO)) whold_lo_q <= wdata_q;
			if (wr_hit(wr_go, wstrb_q, aw_idx_q, IDX_WHOLD_HI)) whold_hi_q <= wdata_q;
		end
	end

	logic cap_mode, pp_mode;
	logic [1:0] es, sm;
	assign cap_mode = common_q[MODE_B];
	assign es = common_q[ES_LSB +: 2];
	assign sm = common_q[SM_LSB +: 2];
	assign pp_mode = ~cap_mode & (sm == SM_PP);

	////////////////////////////////////////////////////////////////////////////
	// Input filter and edge detector

	logic raw_in;
	logic [3:0] flt_w;
	assign raw_in = common_q[INSEL_B] ? PORT2_BIT0_INPUT_I : PORT3_BIT1_INPUT_I;
	assign flt_w = (sm == FLT_4) ? FLT_W4 : (sm == FLT_8) ? FLT_W8 : FLT_W1;

	// A new level must persist for the filter width before it is passed on
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			filt_q <= 1'b0;
			filt_prev_q <= 1'b0;
			flt_cnt_q <= '0;
		end else begin
			filt_prev_q <= filt_q;
			if (raw_in == filt_q) begin
				flt_cnt_q <= '0;
			end else if (flt_cnt_q + 4'h1 >= flt_w) begin
				filt_q <= raw_in;
				flt_cnt_q <= '0;
			end else begin
				flt_cnt_q <= flt_cnt_q + 4'h1;
			end
		end
	end

	logic rise_now, fall_now, edge_sel;
	assign rise_now = filt_q & ~filt_prev_q;
	assign fall_now = ~filt_q & filt_prev_q;
	assign edge_sel = cap_mode & (((es == ES_RISE) | (es == ES_BOTH)) & rise_now |
		((es == ES_FALL) | (es == ES_BOTH)) & fall_now);

	glitch_hold_a: assert property ($changed(filt_q) |->
		$past(flt_cnt_q) + 4'h1 >= $past(flt_w) && filt_q == $past(raw_in))
		else $error("filter passed a short pulse");

	////////////////////////////////////////////////////////////////////////////
	// Timer events

	logic b_cap, b_tc, w_edge_cap, w_to_cap, w_tc, b_start;
	assign b_cap = cap_mode & b_en_q & b_run_q & edge_sel;
	assign b_tc = b_en_q & b_run_q & (b_cnt_q == '0) & ~b_cap;
	assign w_edge_cap = cap_mode & w_en_q & w_run_q & edge_sel & (~w_cfg_q[SP_B] | w_arm_q);
	assign w_to_cap = cap_mode & w_en_q & w_run_q & w_cfg_q[SP_B] & b_tc & ~w_edge_cap;
	assign w_tc = w_en_q & w_run_q & (w_cnt_q == '0) & ~w_edge_cap;
	// In sync mode the first carrier pulse waits for the word output
	assign b_start = b_en_q & ~b_run_q & (~sync_q | w_out_q);

	// Enables: software writes first, terminal-count hand-over after
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			b_en_q <= 1'b0;
			w_en_q <= 1'b0;
		end else begin
			b_en_q <= wr_sync ? wdata_q[SB_EN_B] : wr_bctl ? wdata_q[EN_B] : b_en_q;
			w_en_q <= wr_sync ? wdata_q[SW_EN_B] : wr_wctl ? wdata_q[EN_B] : w_en_q;
			if (!cap_mode && b_tc && b_cfg_q[SP_B]) begin
				b_en_q <= 1'b0;
				if (pp_mode) w_en_q <= 1'b1;
			end
			if (!cap_mode && w_tc && w_cfg_q[SP_B]) begin
				w_en_q <= 1'b0;
				if (pp_mode) b_en_q <= 1'b1;
			end
		end
	end

	// Status flags; clear takes effect on the write, a same-cycle event survives
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			b_to_q <= 1'b0;
			w_to_q <= 1'b0;
			rise_f_q <= 1'b0;
			fall_f_q <= 1'b0;
		end else begin
			b_to_q <= flag_next(b_to_q, b_tc, wr_bctl & wdata_q[TO_B]);
			w_to_q <= flag_next(w_to_q, w_tc, wr_wctl & wdata_q[TO_B]);
			rise_f_q <= flag_next(rise_f_q, b_cap & rise_now,
				wr_com & cap_mode & wdata_q[INIT8_B]);
			fall_f_q <= flag_next(fall_f_q, b_cap & fall_now,
				wr_com & cap_mode & wdata_q[INIT16_B]);
		end
	end

	// Interrupt request pulses, one cycle per event
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			b_irq_q <= 1'b0;
			w_irq_q <= 1'b0;
		end else begin
			b_irq_q <= (b_cap & b_cfg_q[CIE_B]) | (b_tc & b_cfg_q[TIE_B]);
			w_irq_q <= ((w_edge_cap | w_to_cap) & w_cfg_q[CIE_B]) |
				(w_tc & w_cfg_q[TIE_B]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte timer

	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			b_run_q <= 1'b0;
			b_cnt_q <= '0;
			b_out_q <= 1'b0;
			rise_cap_q <= '0;
			fall_cap_q <= '0;
		end else if (!b_en_q) begin
			b_run_q <= 1'b0;
		end else if (cap_mode) begin
			if (!b_run_q) begin
				if (edge_sel) begin
					b_run_q <= 1'b1;
					b_cnt_q <= BYTE_ONES;
				end
			end else if (b_cap) begin
				if (rise_now) rise_cap_q <= ~b_cnt_q;
				if (fall_now) fall_cap_q <= ~b_cnt_q;
				b_cnt_q <= BYTE_ONES;
			end else if (b_tc) begin
				b_cnt_q <= BYTE_ONES;
			end else begin
				b_cnt_q <= b_cnt_q - 8'h01;
			end
		end else if (!b_run_q) begin
			if (b_start) begin
				b_run_q <= 1'b1;
				b_out_q <= common_q[INIT8_B];
				b_cnt_q <= common_q[INIT8_B] ? bhold_hi_q : bhold_lo_q;
			end
		end else if (b_tc) begin
			if (b_cfg_q[SP_B]) begin
				b_run_q <= 1'b0;
			end else begin
				b_out_q <= ~b_out_q;
				b_cnt_q <= b_out_q ? bhold_lo_q : bhold_hi_q;
			end
		end else begin
			b_cnt_q <= b_cnt_q - 8'h01;
		end
	end

	sequence byte_capture_s;
		b_cap && rise_now;
	endsequence
	sequence byte_reload_s;
		b_cnt_q == BYTE_ONES && rise_cap_q == ~$past(b_cnt_q);
	endsequence
	capture_load_a: assert property (byte_capture_s |=> byte_reload_s)
		else $error("rise capture or reload wrong");
	fall_capture_a: assert property (b_cap && fall_now |=>
		fall_cap_q == ~$past(b_cnt_q) && fall_f_q) else $error("fall capture wrong");
	byte_idle_a: assert property (cap_mode && b_en_q && !b_run_q && !edge_sel
		&& $stable(common_q) |=> !b_run_q) else $error("byte timer started without edge");
	byte_timeout_a: assert property (cap_mode && b_tc |=> b_to_q && b_cnt_q == BYTE_ONES)
		else $error("byte timeout not flagged");
	sync_wait_a: assert property (!cap_mode && sync_q && b_en_q && !b_run_q && !w_out_q
		|=> !b_run_q) else $error("carrier started before word output");

	////////////////////////////////////////////////////////////////////////////
	// Word timer

	logic [15:0] w_hold;
	assign w_hold = {whold_hi_q, whold_lo_q};

	// Arming: single-pass written from zero to one allows one edge capture
	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			w_arm_q <= 1'b0;
		end else begin
			w_arm_q <= flag_next(w_arm_q, wr_wctl & wdata_q[SP_B] & ~w_cfg_q[SP_B],
				w_edge_cap);
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			w_run_q <= 1'b0;
			w_cnt_q <= '0;
			w_out_q <= 1'b0;
			w_cap_q <= '0;
		end else begin
			if (!w_en_q) begin
				w_run_q <= 1'b0;
			end else if (!w_run_q) begin
				w_run_q <= 1'b1;
				w_cnt_q <= w_hold;
				if (!cap_mode) w_out_q <= common_q[INIT16_B];
			end else if (cap_mode) begin
				if (w_edge_cap) begin
					w_cap_q <= w_cnt_q;
					w_cnt_q <= w_hold;
				end else if (w_tc) begin
					w_cnt_q <= WORD_ONES;
				end else begin
					w_cnt_q <= w_cnt_q - 16'h0001;
				end
				if (w_to_cap) w_cap_q <= w_cnt_q;
			end else if (w_tc) begin
				if (w_cfg_q[SP_B]) begin
					w_run_q <= 1'b0;
				end else begin
					w_out_q <= ~w_out_q;
					w_cnt_q <= w_hold;
				end
			end else begin
				w_cnt_q <= w_cnt_q - 16'h0001;
			end
			// Forced output levels of the transmit submode override the timer
			if (!cap_mode && sm == SM_LOW) w_out_q <= 1'b0;
			if (!cap_mode && sm == SM_HIGH) w_out_q <= 1'b1;
		end
	end

	word_to_cap_a: assert property (w_to_cap |=> w_cap_q == $past(w_cnt_q)
		&& w_cnt_q == $past(w_cnt_q) - 16'h0001) else $error("timeout capture reloaded");
	// Watches the capture register itself, so a wrongly gated edge capture shows up
	word_ignore_a: assert property (cap_mode && w_cfg_q[SP_B] && !w_arm_q && !b_tc
		|=> $stable(w_cap_q)) else $error("single-pass took an edge");
	word_timeout_a: assert property (cap_mode && w_tc |=> w_to_q && w_cnt_q == WORD_ONES)
		else $error("word timeout wrong");
	pp_handover_a: assert property (pp_mode && b_tc && b_cfg_q[SP_B] && !wr_go
		|=> !b_en_q && w_en_q) else $error("ping-pong byte hand-over failed");
	pp_return_a: assert property (pp_mode && w_tc && w_cfg_q[SP_B] && !wr_go && !b_tc
		|=> b_en_q && !w_en_q) else $error("ping-pong word hand-over failed");

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign BYTE_TIMER_OUTPUT_O = b_out_q;
	assign WORD_TIMER_OUTPUT_O = w_out_q;
	assign BYTE_IRQ_O = b_irq_q;
	assign WORD_IRQ_O = w_irq_q;
	assign AXI_AWREADY_O = awready_q;
	assign AXI_WREADY_O = wready_q;
	assign AXI_BRESP_O = bresp_q;
	assign AXI_BVALID_O = bvalid_q;
	assign AXI_ARREADY_O = arready_q;
	assign AXI_RDATA_O = rdata_q;
	assign AXI_RRESP_O = rresp_q;
	assign AXI_RVALID_O = rvalid_q;

endmodule

// File: carrier_timer_tb_top.sv
`timescale 1ns/100ps
module carrier_timer_tb_top import ctp_pkg::*;;
	typedef struct packed {logic w; logic [3:0] i; logic [7:0] d; logic [1:0] r;} row_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic p2 = 1'b0;
	logic go = 1'b0;
	logic [7:0] hl = 8'h00;
	logic [7:0] ll = 8'h00;
	logic [5:0] awa = 6'h00;
	logic [5:0] ara = 6'h00;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic arv = 1'b0;
	logic [31:0] wd = 32'h0;
	logic car, busy, bo, wo, birq, wirq, awr, wrdy, bv, arr, rv;
	logic [1:0] bresp, rresp;
	logic [31:0] rdat, got;
	int bad_count = 0, n_checks = 0, bi = 0, wi = 0, b0 = 0, w0 = 0;
	row_s rows[13] = '{
		'{1'b0, IDX_SYNC, 8'h1F, RESP_OKAY},
		'{1'b0, IDX_BYTE_CTL, 8'h00, RESP_OKAY},
		'{1'b1, IDX_SYNC, 8'h20, RESP_OKAY},
		'{1'b0, IDX_SYNC, 8'h3F, RESP_OKAY},
		'{1'b1, IDX_SYNC, 8'h00, RESP_OKAY},
		'{1'b1, IDX_BHOLD_LO, 8'hA5, RESP_OKAY},
		'{1'b0, IDX_BHOLD_LO, 8'hA5, RESP_OKAY},
		'{1'b1, IDX_WORD_CTL, 8'h18, RESP_OKAY},
		'{1'b0, IDX_WORD_CTL, 8'h18, RESP_OKAY},
		'{1'b1, IDX_RISE_CAP, 8'h55, RESP_OKAY},
		'{1'b0, IDX_RISE_CAP, 8'h00, RESP_OKAY},
		'{1'b0, 4'hB, 8'h00, RESP_SLVERR},
		'{1'b1, 4'hB, 8'h12, RESP_SLVERR}};

	// Clock and interrupt tallies; pulses last one cycle, so count every edge
	always #5 clk = ~clk;
	always @(posedge clk) begin
		bi <= bi + 32'(birq === 1'b1);
		wi <= wi + 32'(wirq === 1'b1);
	end

	// Strobes and response readies tied: every byte lane used, answers taken at once
	carrier_timer dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .PORT3_BIT1_INPUT_I(car),
		.PORT2_BIT0_INPUT_I(p2), .BYTE_TIMER_OUTPUT_O(bo), .WORD_TIMER_OUTPUT_O(wo),
		.BYTE_IRQ_O(birq), .WORD_IRQ_O(wirq), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv),
		.AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv),
		.AXI_WREADY_O(wrdy), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bv), .AXI_BREADY_I(1'b1),
		.AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdat),
		.AXI_RRESP_O(rresp), .AXI_RVALID_O(rv), .AXI_RREADY_I(1'b1));
	carrier_src src_u (.clk_i(clk), .go_i(go), .hi_len_i(hl), .lo_len_i(ll), .pin_o(car),
		.busy_o(busy));

	////////////////////////////////////////////////////////////////////////////////
	// Reporting
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic bad(input string m);
		$display("BAD %0t %s", $time, m);
		bad_count++;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) bad($sformatf("%s got %h exp %h", m, g, e));
	endtask
	// Capture counts depend on edge latency, so they are judged within a window
	task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi,
			input string m);
		n_checks++;
		if ($isunknown(g) || g < lo || g > hi) bad($sformatf("%s got %0d", m, g));
	endtask
	task automatic tmo();
		bad("wait ran out");
		results();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus master; each task starts just after an edge, valids drop once taken
	task automatic axw(input logic [3:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
		int n;
		awa <= {i, 2'b00};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (bv === 1'b1) break;
			awv <= awv && !awr;
			wv <= wv && !wrdy;
		end
		if (n == 50) tmo();
		chk({30'h0, bresp}, {30'h0, er}, "write response");
	endtask
	task automatic axr(input logic [3:0] i, output logic [31:0] g, input logic [1:0] er = 2'h0);
		int n;
		ara <= {i, 2'b00};
		arv <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (rv === 1'b1) break;
			arv <= arv && !arr;
		end
		if (n == 50) tmo();
		g = rdat;
		chk({30'h0, rresp}, {30'h0, er}, "read response");
	endtask
	task automatic rc(input logic [3:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
		axr(i, got, er);
		chk(got, {24'h0, e}, "register value");
	endtask
	// One burst from the far side, waiting until it has gone idle again
	task automatic pulse(input logic [7:0] h, input logic [7:0] l);
		int n;
		hl <= h;
		ll <= l;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (n = 0; n < 600; n++) begin
			@(posedge clk);
			if (busy === 1'b0) break;
		end
		if (n == 600) tmo();
	endtask
	// Pulse on the second carrier input, long enough to pass any filter width
	task automatic p2_pulse();
		p2 <= 1'b1;
		repeat (12) @(posedge clk);
		p2 <= 1'b0;
		repeat (12) @(posedge clk);
	endtask
	// Capture-mode common control with both edges; writing ones clears both flags
	function automatic logic [7:0] cm(input logic s, input logic [1:0] f);
		return {1'b1, s, ES_BOTH, f, 2'b11};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[k]) begin
			if (rows[k].w) begin
				axw(rows[k].i, rows[k].d, rows[k].r);
			end else begin
				rc(rows[k].i, rows[k].d, rows[k].r);
			end
		end
		$display("register table done");
		axw(IDX_BHOLD_LO, BYTE_ONES);
		axw(IDX_BHOLD_HI, BYTE_ONES);
		axw(IDX_COMMON, cm(1'b0, 2'h0));
		axw(IDX_WORD_CTL, 8'hC4);
		b0 = bi;
		axw(IDX_BYTE_CTL, 8'h84);
		pulse(8'd20, 8'd40);
		axr(IDX_FALL_CAP, got);
		rng(got, 17, 23, "fall capture");
		pulse(8'd4, 8'd4);
		axr(IDX_RISE_CAP, got);
		rng(got, 38, 48, "rise capture");
		rc(IDX_COMMON, cm(1'b0, 2'h0));
		chk(32'(bi - b0), 32'd3, "byte capture irqs");
		w0 = wi;
		repeat (300) @(posedge clk);
		rc(IDX_BYTE_CTL, 8'hA4);
		chk(32'(wi - w0), 32'd1, "word capture on byte timeout");
		axr(IDX_WORD_CAP, got);
		rng(got, 32'h0000FE80, 32'h0000FF00, "word capture value");
		$display("capture test done");
		axw(IDX_COMMON, cm(1'b0, FLT_8));
		pulse(8'd3, 8'd12);
		rc(IDX_COMMON, cm(1'b0, FLT_8) & 8'hFC);
		pulse(8'd12, 8'd12);
		rc(IDX_COMMON, cm(1'b0, FLT_8));
		axw(IDX_COMMON, cm(1'b1, 2'h0));
		pulse(8'd12, 8'd12);
		rc(IDX_COMMON, cm(1'b1, 2'h0) & 8'hFC);
		p2_pulse();
		rc(IDX_COMMON, cm(1'b1, 2'h0));
		// Single-edge selects: rise only, then fall only behind the short filter
		axw(IDX_COMMON, {2'b11, ES_RISE, 4'b0011});
		p2_pulse();
		rc(IDX_COMMON, {2'b11, ES_RISE, 4'b0010});
		axw(IDX_COMMON, {2'b11, ES_FALL, FLT_4, 2'b11});
		p2_pulse();
		rc(IDX_COMMON, {2'b11, ES_FALL, FLT_4, 2'b01});
		$display("filter and select test done");
		// Stop first, clear flags in a later write: a stop lands one cycle late
		axw(IDX_BYTE_CTL, 8'h00);
		axw(IDX_WORD_CTL, 8'h00);
		axw(IDX_BYTE_CTL, 8'h20);
		axw(IDX_WORD_CTL, 8'h20);
		axw(IDX_WHOLD_LO, 8'h10);
		axw(IDX_WHOLD_HI, 8'h00);
		w0 = wi;
		axw(IDX_WORD_CTL, 8'h82);
		repeat (40) @(posedge clk);
		rc(IDX_WORD_CTL, 8'hA2);
		chk(32'(wi - w0), 32'd1, "word timeout irqs");
		$display("word timeout test done");
		axw(IDX_WORD_CTL, 8'h00);
		axw(IDX_WORD_CTL, 8'h20);
		axw(IDX_BHOLD_LO, 8'h03);
		axw(IDX_BHOLD_HI, 8'h05);
		axw(IDX_WHOLD_LO, 8'h07);
		axw(IDX_COMMON, {4'h0, SM_PP, 2'b10});
		axw(IDX_WORD_CTL, 8'h42);
		b0 = bi;
		w0 = wi;
		axw(IDX_BYTE_CTL, 8'hC2);
		repeat (2) @(posedge clk);
		chk({31'h0, bo}, 32'd1, "byte output initial level");
		repeat (200) @(posedge clk);
		rng(bi - b0, 6, 30, "byte terminal irqs");
		rng(wi - w0, 6, 30, "word terminal irqs");
		rng((bi - b0) - (wi - w0) + 1, 0, 2, "alternation");
		axw(IDX_COMMON, 8'h02);
		repeat (50) @(posedge clk);
		b0 = bi;
		w0 = wi;
		repeat (100) @(posedge clk);
		chk(32'((bi - b0) + (wi - w0)), 32'd0, "ping-pong ended");
		$display("ping-pong test done");
		// Sync mode: the byte timer waits until the word output goes high
		axw(IDX_SYNC, 8'h20);
		axw(IDX_COMMON, {4'h0, SM_LOW, 2'b00});
		b0 = bi;
		axw(IDX_BYTE_CTL, 8'hC2);
		repeat (20) @(posedge clk);
		chk({30'h0, bo, wo}, 32'h2, "outputs while sync waits");
		chk(32'(bi - b0), 32'd0, "byte ran before word output");
		rc(IDX_SYNC, 8'h7F);
		axw(IDX_COMMON, {4'h0, SM_HIGH, 2'b00});
		repeat (20) @(posedge clk);
		chk({30'h0, bo, wo}, 32'h1, "outputs after sync release");
		chk(32'(bi - b0), 32'd1, "byte run after sync release");
		$display("sync test done");
		// Reset after the byte run must clear the sync bit and both enables again
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rc(IDX_SYNC, 8'h1F);
		$display("reset test done");
		results();
	end
endmodule

// File: ctp_pkg.sv
// Contract
// - Edge detector watches selected pin, pulses rise or fall per edge-select field.
// - Pulses shorter than the glitch-filter width are dropped before edge detection.
// - In capture mode byte timer idles until the first selected edge.
// - Each later edge stores the one's complement of byte count in a capture register.
// - Rising-edge captures go low register, falling-edge captures go high register.
// - After a capture set matching edge flag; interrupt if capture enable set.
// - Each capture reloads byte timer with all ones and it keeps counting.
// - Byte timer at zero sets timeout flag, interrupts if enabled, reloads ones.
// - Capture mode with word single-pass set: word timer ignores edges, keeps counting.
// - Then byte timeout makes word timer capture without reload, interrupt if enabled.
// - Writing single-pass zero then one arms one edge capture and reload.
// - Word timer at zero reloads all ones, sets timeout flag, interrupts if enabled.
// - Ping-pong byte start drives initial output level, loads hold byte by level.
// - Byte terminal count disables byte, enables word, sets word output, loads hold.
// - Word terminal count stops word timer and re-enables byte timer, repeating.
// - In ping-pong each terminal count interrupts if its timeout enable is set.
// - Sync mode holds first byte carrier pulse until the word output is high.
// - Sync-mode enable bit clears on reset.
package ctp_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [3:0] IDX_BYTE_CTL = 4'h0;
	localparam logic [3:0] IDX_COMMON = 4'h1;
	localparam logic [3:0] IDX_WORD_CTL = 4'h2;
	localparam logic [3:0] IDX_SYNC = 4'h3;
	localparam logic [3:0] IDX_BHOLD_LO = 4'h4;
	localparam logic [3:0] IDX_BHOLD_HI = 4'h5;
	localparam logic [3:0] IDX_WHOLD_LO = 4'h6;
	localparam logic [3:0] IDX_WHOLD_HI = 4'h7;
	localparam logic [3:0] IDX_RISE_CAP = 4'h8;
	localparam logic [3:0] IDX_FALL_CAP = 4'h9;
	localparam logic [3:0] IDX_WORD_CAP = 4'hA;
	// Timer control fields (byte and word share a layout)
	localparam int EN_B = 7;
	localparam int SP_B = 6;
	localparam int TO_B = 5;
	localparam int CIE_B = 2;
	localparam int TIE_B = 1;
	localparam logic [7:0] CFG_MASK = 8'h5F;
	// Common control fields
	localparam int MODE_B = 7;
	localparam int INSEL_B = 6;
	localparam int ES_LSB = 4;
	localparam int SM_LSB = 2;
	localparam int INIT8_B = 1;
	localparam int INIT16_B = 0;
	// Sync register fields
	localparam int SW_EN_B = 7;
	localparam int SB_EN_B = 6;
	localparam int SYNC_B = 5;
	localparam logic [4:0] RSV_ONES = 5'h1F;
	// Field encodings
	localparam logic [1:0] ES_FALL = 2'h0;
	localparam logic [1:0] ES_RISE = 2'h1;
	localparam logic [1:0] ES_BOTH = 2'h2;
	localparam logic [1:0] SM_PP = 2'h1;
	localparam logic [1:0] SM_LOW = 2'h2;
	localparam logic [1:0] SM_HIGH = 2'h3;
	localparam logic [1:0] FLT_4 = 2'h1;
	localparam logic [1:0] FLT_8 = 2'h2;
	localparam logic [3:0] FLT_W1 = 4'h1;
	localparam logic [3:0] FLT_W4 = 4'h4;
	localparam logic [3:0] FLT_W8 = 4'h8;
	// Values
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [15:0] WORD_ONES = 16'hFFFF;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
